//--- hw/dac_pio_pkg.sv
// Shared offsets, field positions, reset values and encodings for the converter and port block
package dac_pio_pkg;

	// Register offsets above the board base address
	localparam logic [3:0] OFS_DAC0_LOW_BYTE = 4'h0;
	localparam logic [3:0] OFS_DAC0_HIGH_BYTE = 4'h1;
	localparam logic [3:0] OFS_DAC1_LOW_BYTE = 4'h2;
	localparam logic [3:0] OFS_DAC1_HIGH_BYTE = 4'h3;
	localparam logic [3:0] OFS_DAC2_LOW_BYTE = 4'h4;
	localparam logic [3:0] OFS_DAC2_HIGH_BYTE = 4'h5;
	localparam logic [3:0] OFS_DAC3_LOW_BYTE = 4'h6;
	localparam logic [3:0] OFS_DAC3_HIGH_BYTE = 4'h7;
	localparam logic [3:0] OFS_DAC4_LOW_BYTE = 4'h8;
	localparam logic [3:0] OFS_DAC4_HIGH_BYTE = 4'h9;
	localparam logic [3:0] OFS_DAC5_LOW_BYTE = 4'hA;
	localparam logic [3:0] OFS_DAC5_HIGH_BYTE = 4'hB;
	localparam logic [3:0] OFS_FIRST_PORT_DATA = 4'hC;
	localparam logic [3:0] OFS_SECOND_PORT_DATA = 4'hD;
	localparam logic [3:0] OFS_THIRD_PORT_DATA = 4'hE;
	localparam logic [3:0] OFS_PORT_CONFIGURATION = 4'hF;

	// Channel count and code width
	localparam int NUM_CHANNELS = 6;
	localparam int CODE_WIDTH = 16;

	// Configuration byte field positions
	localparam int CFG_MODE_SET_FLAG = 7;
	localparam int CFG_GROUP_ONE_MODE_UPPER = 6;
	localparam int CFG_GROUP_ONE_MODE_LOWER = 5;
	localparam int CFG_FIRST_PORT_DIR = 4;
	localparam int CFG_UPPER_NIBBLE_DIR = 3;
	localparam int CFG_GROUP_TWO_MODE = 2;
	localparam int CFG_SECOND_PORT_DIR = 1;
	localparam int CFG_LOWER_NIBBLE_DIR = 0;

	// Reset values
	localparam logic [15:0] RST_DAC_CODE = 16'h0000;
	localparam logic [7:0] RST_PORT_OUT = 8'h00;
	localparam logic RST_DIR_INPUT = 1'b1;
	localparam logic [7:0] RD_NOTHING = 8'h00;

	// Group one mode decode
	typedef enum logic [1:0] {
		G1_SIMPLE = 2'b00,
		G1_STROBED = 2'b01,
		G1_BIDIR = 2'b10
	} group_one_mode_e;

	// Group two mode decode
	typedef enum logic {
		G2_SIMPLE = 1'b0,
		G2_STROBED = 1'b1
	} group_two_mode_e;

endpackage

//--- hw/dac_channel.sv
// One converter channel: pending load latch and output latch
`timescale 1ns/1ps

module dac_channel (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// Load strobes
	input wire logic i_wr_low,
	input wire logic i_wr_high,
	input wire logic [7:0] i_wdata,
	input wire logic i_held_update_setting,
	input wire logic i_transfer,
	// Converter code
	output logic [15:0] o_code
);

	typedef struct packed {
		logic [15:0] pending;
		logic [15:0] out;
	} chan_s;

	chan_s state_reg;
	chan_s state_next;

	// Load and transfer
	always_comb begin
		state_next = state_reg;
		if (i_wr_low) begin
			state_next.pending[7:0] = i_wdata;
		end
		if (i_wr_high) begin
			state_next.pending[15:8] = i_wdata;
			if (!i_held_update_setting) begin
				state_next.out = {i_wdata, state_reg.pending[7:0]};
			end
		end
		if (i_transfer) begin
			state_next.out = state_reg.pending;
		end
	end

	// State register
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			state_reg <= {dac_pio_pkg::RST_DAC_CODE, dac_pio_pkg::RST_DAC_CODE};
		end else begin
			state_reg <= state_next;
		end
	end

	assign o_code = state_reg.out;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	// Individual update on the high byte
	high_update_a: assert property (
		i_wr_high && !i_held_update_setting && !i_transfer
		|=> o_code == {$past(i_wdata), $past(state_reg.pending[7:0])}
	) else $error("high byte write did not update output");

	// Held update leaves the output alone on a write
	held_no_update_a: assert property (
		i_held_update_setting && (i_wr_high || i_wr_low) && !i_transfer |=> $stable(o_code)
	) else $error("held mode output changed on write");

	// Transfer copies the pending word
	held_transfer_a: assert property (
		i_transfer && !i_wr_low && !i_wr_high |=> o_code == $past(state_reg.pending)
	) else $error("transfer did not copy pending word");

	// Low byte write never moves the output
	low_write_hold_a: assert property (
		i_wr_low && !i_transfer |=> $stable(o_code)
	) else $error("low byte write changed output");

endmodule

//--- hw/dac_loader_and_parallel_ports.sv
// Converter loader and three-port parallel unit behind a sixteen-byte register block
`timescale 1ns/1ps

module dac_loader_and_parallel_ports (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// Register access, offset above the board base address
	input wire logic i_sel,
	input wire logic [3:0] i_addr,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata,
	// Board strap: high selects held simultaneous update
	input wire logic i_held_update_setting,
	// Converter codes, channel n in bits 16n+15..16n
	output logic [95:0] o_dac_code,
	// First port lines
	input wire logic [7:0] i_first_port,
	output logic [7:0] o_first_port,
	output logic [7:0] o_first_port_oe,
	// Second port lines
	input wire logic [7:0] i_second_port,
	output logic [7:0] o_second_port,
	output logic [7:0] o_second_port_oe,
	// Third port lines
	input wire logic [7:0] i_third_port,
	output logic [7:0] o_third_port,
	output logic [7:0] o_third_port_oe,
	// Decoded group modes
	output logic [1:0] o_group_one_mode,
	output logic o_group_two_mode
);

	typedef struct packed {
		logic [7:0] first_out;
		logic [7:0] second_out;
		logic [7:0] third_out;
		logic dir_first;
		logic dir_upper;
		logic dir_second;
		logic dir_lower;
		logic [1:0] g1_mode;
		logic g2_mode;
		logic [7:0] rdata;
		logic cfg_seen;
	} pio_s;

	pio_s state_reg;
	pio_s state_next;

	logic wr_hit;
	logic rd_hit;
	logic dac_space;
	logic [2:0] chan_sel;
	logic transfer;
	logic [7:0] third_live;

	// Address decode over the sixteen offsets
	assign wr_hit = i_sel && i_wr;
	assign rd_hit = i_sel && i_rd;
	assign dac_space = i_addr <= dac_pio_pkg::OFS_DAC5_HIGH_BYTE;
	assign chan_sel = i_addr[3:1];
	assign transfer = rd_hit && dac_space && i_held_update_setting;

	// Third port read value, each nibble by its own direction
	assign third_live = {
		state_reg.dir_upper ? i_third_port[7:4] : state_reg.third_out[7:4],
		state_reg.dir_lower ? i_third_port[3:0] : state_reg.third_out[3:0]
	};

	// Converter channels
	genvar n;
	generate
		for (n = 0; n < dac_pio_pkg::NUM_CHANNELS; n++) begin : g_chan
			dac_channel u_chan (
				.i_clk(i_clk),
				.i_reset(i_reset),
				.i_wr_low(wr_hit && dac_space && chan_sel == 3'(n) && !i_addr[0]),
				.i_wr_high(wr_hit && dac_space && chan_sel == 3'(n) && i_addr[0]),
				.i_wdata(i_wdata),
				.i_held_update_setting(i_held_update_setting),
				.i_transfer(transfer),
				.o_code(o_dac_code[n*16 +: 16])
			);
		end
	endgenerate

	// Port writes, configuration writes and read data
	always_comb begin
		state_next = state_reg;
		if (wr_hit) begin
			case (i_addr)
				dac_pio_pkg::OFS_FIRST_PORT_DATA: begin
					state_next.first_out = i_wdata;
				end
				dac_pio_pkg::OFS_SECOND_PORT_DATA: begin
					state_next.second_out = i_wdata;
				end
				dac_pio_pkg::OFS_THIRD_PORT_DATA: begin
					state_next.third_out = i_wdata;
				end
				dac_pio_pkg::OFS_PORT_CONFIGURATION: begin
					if (i_wdata[dac_pio_pkg::CFG_MODE_SET_FLAG]) begin
						state_next.dir_first = i_wdata[dac_pio_pkg::CFG_FIRST_PORT_DIR];
						state_next.dir_upper = i_wdata[dac_pio_pkg::CFG_UPPER_NIBBLE_DIR];
						state_next.dir_second = i_wdata[dac_pio_pkg::CFG_SECOND_PORT_DIR];
						state_next.dir_lower = i_wdata[dac_pio_pkg::CFG_LOWER_NIBBLE_DIR];
						// Upper mode bit set means bidirectional, lower bit ignored
						if (i_wdata[dac_pio_pkg::CFG_GROUP_ONE_MODE_UPPER]) begin
							state_next.g1_mode = dac_pio_pkg::G1_BIDIR;
						end else if (i_wdata[dac_pio_pkg::CFG_GROUP_ONE_MODE_LOWER]) begin
							state_next.g1_mode = dac_pio_pkg::G1_STROBED;
						end else begin
							state_next.g1_mode = dac_pio_pkg::G1_SIMPLE;
						end
						state_next.g2_mode = i_wdata[dac_pio_pkg::CFG_GROUP_TWO_MODE];
						state_next.cfg_seen = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end
		if (rd_hit) begin
			case (i_addr)
				dac_pio_pkg::OFS_FIRST_PORT_DATA: begin
					state_next.rdata = state_reg.dir_first ? i_first_port
						: state_reg.first_out;
				end
				dac_pio_pkg::OFS_SECOND_PORT_DATA: begin
					state_next.rdata = state_reg.dir_second ? i_second_port
						: state_reg.second_out;
				end
				dac_pio_pkg::OFS_THIRD_PORT_DATA: begin
					state_next.rdata = third_live;
				end
				default: begin
					state_next.rdata = dac_pio_pkg::RD_NOTHING;
				end
			endcase
		end
	end

	// State register; reset leaves every line an input
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			state_reg.first_out <= dac_pio_pkg::RST_PORT_OUT;
			state_reg.second_out <= dac_pio_pkg::RST_PORT_OUT;
			state_reg.third_out <= dac_pio_pkg::RST_PORT_OUT;
			state_reg.dir_first <= dac_pio_pkg::RST_DIR_INPUT;
			state_reg.dir_upper <= dac_pio_pkg::RST_DIR_INPUT;
			state_reg.dir_second <= dac_pio_pkg::RST_DIR_INPUT;
			state_reg.dir_lower <= dac_pio_pkg::RST_DIR_INPUT;
			state_reg.g1_mode <= dac_pio_pkg::G1_SIMPLE;
			state_reg.g2_mode <= dac_pio_pkg::G2_SIMPLE;
			state_reg.rdata <= dac_pio_pkg::RD_NOTHING;
			state_reg.cfg_seen <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	// Pin drive: a port drives its lines only while configured as output
	assign o_first_port = state_reg.first_out;
	assign o_first_port_oe = {8{~state_reg.dir_first}};
	assign o_second_port = state_reg.second_out;
	assign o_second_port_oe = {8{~state_reg.dir_second}};
	assign o_third_port = state_reg.third_out;
	assign o_third_port_oe = {{4{~state_reg.dir_upper}}, {4{~state_reg.dir_lower}}};
	assign o_rdata = state_reg.rdata;
	assign o_group_one_mode = state_reg.g1_mode;
	assign o_group_two_mode = state_reg.g2_mode;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	// Configuration register reads back nothing
	cfg_read_zero_a: assert property (
		rd_hit && i_addr == dac_pio_pkg::OFS_PORT_CONFIGURATION
		|=> o_rdata == dac_pio_pkg::RD_NOTHING
	) else $error("configuration read returned data");

	// Output port reads back the held byte
	rd_output_port_a: assert property (
		rd_hit && i_addr == dac_pio_pkg::OFS_FIRST_PORT_DATA && !state_reg.dir_first
		|=> o_rdata == $past(state_reg.first_out)
	) else $error("output port readback wrong");

	// Input port reads the lines at the read edge
	rd_input_port_a: assert property (
		rd_hit && i_addr == dac_pio_pkg::OFS_SECOND_PORT_DATA && state_reg.dir_second
		|=> o_rdata == $past(i_second_port)
	) else $error("input port read not live");

	// No line is driven before a mode-set write
	reset_inputs_a: assert property (
		!state_reg.cfg_seen |-> (o_first_port_oe == 8'h00 && o_second_port_oe == 8'h00
			&& o_third_port_oe == 8'h00)
	) else $error("line driven after reset without configuration");

	// Direction bits steer the enables
	cfg_dir_a: assert property (
		wr_hit && i_addr == dac_pio_pkg::OFS_PORT_CONFIGURATION
			&& i_wdata[dac_pio_pkg::CFG_MODE_SET_FLAG]
		|=> o_first_port_oe == {8{~$past(i_wdata[dac_pio_pkg::CFG_FIRST_PORT_DIR])}}
			&& o_third_port_oe[7:4] == {4{~$past(i_wdata[dac_pio_pkg::CFG_UPPER_NIBBLE_DIR])}}
			&& o_third_port_oe[3:0] == {4{~$past(i_wdata[dac_pio_pkg::CFG_LOWER_NIBBLE_DIR])}}
	) else $error("direction enables wrong after configuration");

	// Mode fields decode
	mode_decode_a: assert property (
		wr_hit && i_addr == dac_pio_pkg::OFS_PORT_CONFIGURATION
			&& i_wdata[dac_pio_pkg::CFG_MODE_SET_FLAG]
		|=> o_group_one_mode == ($past(i_wdata[dac_pio_pkg::CFG_GROUP_ONE_MODE_UPPER])
			? dac_pio_pkg::G1_BIDIR
			: {1'b0, $past(i_wdata[dac_pio_pkg::CFG_GROUP_ONE_MODE_LOWER])})
			&& o_group_two_mode == $past(i_wdata[dac_pio_pkg::CFG_GROUP_TWO_MODE])
	) else $error("mode field decode wrong");

	// Writes without the mode-set flag leave the configuration alone
	no_mode_set_a: assert property (
		wr_hit && i_addr == dac_pio_pkg::OFS_PORT_CONFIGURATION
			&& !i_wdata[dac_pio_pkg::CFG_MODE_SET_FLAG]
		|=> $stable(o_first_port_oe) && $stable(o_second_port_oe) && $stable(o_third_port_oe)
			&& $stable(o_group_one_mode) && $stable(o_group_two_mode)
	) else $error("configuration changed without mode-set flag");

	// Third port write lands as all eight bits
	third_write_a: assert property (
		wr_hit && i_addr == dac_pio_pkg::OFS_THIRD_PORT_DATA |=> o_third_port == $past(i_wdata)
	) else $error("third port write lost");

	// Held read updates channel zero from its pending word
	held_read_a: assert property (
		transfer && !wr_hit |=> o_dac_code[15:0] == $past(g_chan[0].u_chan.state_reg.pending)
	) else $error("held read did not transfer");

	// Converter high byte of channel five lands in the right slice
	chan_map_a: assert property (
		wr_hit && i_addr == dac_pio_pkg::OFS_DAC5_HIGH_BYTE && !i_held_update_setting && !transfer
		|=> o_dac_code[95:88] == $past(i_wdata)
	) else $error("channel five high byte misplaced");

	// Converter reads return nothing useful
	dac_read_zero_a: assert property (
		rd_hit && dac_space |=> o_rdata == dac_pio_pkg::RD_NOTHING
	) else $error("converter read returned data");

	// First port input reads the lines at the read edge
	rd_first_input_a: assert property (
		rd_hit && i_addr == dac_pio_pkg::OFS_FIRST_PORT_DATA && state_reg.dir_first
		|=> o_rdata == $past(i_first_port)
	) else $error("first port input read not live");

	// Second port output reads back the held byte
	rd_second_output_a: assert property (
		rd_hit && i_addr == dac_pio_pkg::OFS_SECOND_PORT_DATA && !state_reg.dir_second
		|=> o_rdata == $past(state_reg.second_out)
	) else $error("second port readback wrong");

	// Third port read takes each nibble by its own direction
	rd_third_split_a: assert property (
		rd_hit && i_addr == dac_pio_pkg::OFS_THIRD_PORT_DATA
		|=> o_rdata[7:4] == ($past(state_reg.dir_upper) ? $past(i_third_port[7:4])
			: $past(state_reg.third_out[7:4]))
			&& o_rdata[3:0] == ($past(state_reg.dir_lower) ? $past(i_third_port[3:0])
			: $past(state_reg.third_out[3:0]))
	) else $error("third port nibble read wrong");

	// First port write lands in its latch
	first_write_a: assert property (
		wr_hit && i_addr == dac_pio_pkg::OFS_FIRST_PORT_DATA |=> o_first_port == $past(i_wdata)
	) else $error("first port write lost");

	// Second port write lands in its latch
	second_write_a: assert property (
		wr_hit && i_addr == dac_pio_pkg::OFS_SECOND_PORT_DATA
		|=> o_second_port == $past(i_wdata)
	) else $error("second port write lost");

	// Second port direction follows its configuration bit
	cfg_second_dir_a: assert property (
		wr_hit && i_addr == dac_pio_pkg::OFS_PORT_CONFIGURATION
			&& i_wdata[dac_pio_pkg::CFG_MODE_SET_FLAG]
		|=> o_second_port_oe == {8{~$past(i_wdata[dac_pio_pkg::CFG_SECOND_PORT_DIR])}}
	) else $error("second port enable wrong after configuration");

	// A strobe without board select changes nothing
	no_sel_a: assert property (
		!i_sel |=> $stable(o_dac_code) && $stable(o_rdata) && $stable(o_first_port_oe)
			&& $stable(o_third_port)
	) else $error("unselected access changed state");

	// Held read updates the last channel one cycle after the read
	held_read_last_a: assert property (
		transfer && !wr_hit |=> o_dac_code[95:80] == $past(g_chan[5].u_chan.state_reg.pending)
	) else $error("held read missed channel five");

	// Held mode converter writes leave every output alone
	held_write_a: assert property (
		wr_hit && dac_space && i_held_update_setting |=> $stable(o_dac_code)
	) else $error("held mode write moved an output");

	// Port and configuration writes never touch the converters
	port_space_a: assert property (
		wr_hit && !dac_space |=> $stable(o_dac_code)
	) else $error("port write changed a converter");

	// A configuration write keeps the port output latches
	cfg_keeps_ports_a: assert property (
		wr_hit && i_addr == dac_pio_pkg::OFS_PORT_CONFIGURATION
		|=> $stable(o_first_port) && $stable(o_second_port) && $stable(o_third_port)
	) else $error("configuration write changed port data");

	// Read data stands until the next read
	rdata_hold_a: assert property (
		!rd_hit |=> $stable(o_rdata)
	) else $error("read data changed without a read");

endmodule

//--- verif/port_lines_model.sv
// Far-side model of the 24 port lines: external drivers plus the block's own drive
`timescale 1ns/1ps

module port_lines_model (
	// Block drive
	input wire logic [23:0] i_out,
	input wire logic [23:0] i_oe,
	// External level offered on lines the block leaves undriven
	input wire logic [23:0] i_far,
	// Resolved line levels
	output logic [23:0] o_lines
);
	// A driven line shows the block's value, any other shows the external level
	assign o_lines = (i_oe & i_out) | (~i_oe & i_far);
endmodule

//--- verif/testbench.sv
// Register-level testbench for the converter loader and parallel port block
`timescale 1ns/1ps

module testbench;
	logic i_clk = 1'b0;
	logic i_reset = 1'b1;
	logic i_sel = 1'b0;
	logic [3:0] i_addr = 4'h0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [7:0] i_wdata = 8'h00;
	logic [7:0] o_rdata;
	logic i_held_update_setting = 1'b0;
	logic [95:0] o_dac_code;
	logic [23:0] ext = 24'hA5C33C;
	logic [23:0] pout;
	logic [23:0] poe;
	logic [23:0] lines;
	logic [1:0] o_group_one_mode;
	logic o_group_two_mode;
	logic [95:0] exp_code = '0;
	logic [95:0] pend = '0;
	logic [7:0] rv;
	logic [7:0] lo;
	logic [7:0] hi;
	logic [7:0] cfg;
	logic [7:0] modes [5] = '{8'h80, 8'hA0, 8'hC0, 8'hE0, 8'h84};
	int err_count = 0;
	int n_tests = 0;
	int cycles = 0;

	// Clock, 40 ns period
	always #20 i_clk = ~i_clk;

	dac_loader_and_parallel_ports u_dac_loader_and_parallel_ports (
		.i_clk(i_clk), .i_reset(i_reset), .i_sel(i_sel), .i_addr(i_addr),
		.i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata),
		.i_held_update_setting(i_held_update_setting), .o_dac_code(o_dac_code),
		.i_first_port(lines[7:0]), .o_first_port(pout[7:0]), .o_first_port_oe(poe[7:0]),
		.i_second_port(lines[15:8]), .o_second_port(pout[15:8]),
		.o_second_port_oe(poe[15:8]),
		.i_third_port(lines[23:16]), .o_third_port(pout[23:16]),
		.o_third_port_oe(poe[23:16]),
		.o_group_one_mode(o_group_one_mode), .o_group_two_mode(o_group_two_mode)
	);

	port_lines_model u_port_lines_model (
		.i_out(pout), .i_oe(poe), .i_far(ext), .o_lines(lines)
	);

	// Compare and count
	task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One register access: strobe for one edge, read data taken a cycle later
	task automatic acc(input logic wr, input logic [3:0] a, input logic [7:0] d);
		@(negedge i_clk);
		i_sel = 1'b1;
		i_wr = wr;
		i_rd = ~wr;
		i_addr = a;
		i_wdata = d;
		@(negedge i_clk);
		i_sel = 1'b0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		rv = o_rdata;
	endtask

	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Cut a hang short
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 2000) begin
			err_count++;
			final_report();
		end
	end

	initial begin
		repeat (10) @(negedge i_clk);
		i_reset = 1'b0;
		chk(poe, 24'h000000);
		chk(o_dac_code, exp_code);
		// Individual update: low byte waits, high byte moves the word out
		for (int n = 0; n < 6; n++) begin
			lo = 8'(17 * n + 15);
			hi = 8'(240 - 16 * n);
			acc(1'b1, 4'(2 * n), lo);
			chk(o_dac_code, exp_code);
			acc(1'b1, 4'(2 * n + 1), hi);
			exp_code[16*n +: 16] = {hi, lo};
			chk(o_dac_code, exp_code);
		end
		// Strobes without board select are ignored
		@(negedge i_clk);
		i_wr = 1'b1;
		i_addr = 4'h1;
		i_wdata = 8'hFF;
		@(negedge i_clk);
		i_wr = 1'b0;
		chk(o_dac_code, exp_code);
		acc(1'b0, 4'h3, 8'h00);
		chk(o_dac_code, exp_code);
		chk(rv, 8'h00);
		// Held update: nothing moves until a converter address is read
		i_held_update_setting = 1'b1;
		for (int n = 0; n < 6; n++) begin
			lo = 8'(200 - 9 * n);
			hi = 8'(5 * n + 1);
			acc(1'b1, 4'(2 * n), lo);
			acc(1'b1, 4'(2 * n + 1), hi);
			pend[16*n +: 16] = {hi, lo};
			chk(o_dac_code, exp_code);
		end
		acc(1'b0, 4'hB, 8'h00);
		exp_code = pend;
		chk(o_dac_code, exp_code);
		chk(rv, 8'h00);
		i_held_update_setting = 1'b0;
		// Inputs after reset read live line levels
		for (int p = 0; p < 3; p++) begin
			ext = ext ^ 24'h5A5A5A;
			acc(1'b0, 4'(12 + p), 8'h00);
			chk(rv, ext[8*p +: 8]);
		end
		acc(1'b1, 4'hF, 8'h0F);
		chk(poe, 24'h000000);
		// Every direction combination, third port split into nibbles
		for (int d = 0; d < 16; d++) begin
			cfg = {1'b1, 2'b00, 1'(d >> 3), 1'(d >> 2), 1'b0, 1'(d >> 1), 1'(d)};
			acc(1'b1, 4'hF, cfg);
			chk(poe, {{4{~cfg[3]}}, {4{~cfg[0]}}, {8{~cfg[1]}}, {8{~cfg[4]}}});
			ext[23:16] = 8'(d * 37);
			lo = 8'(d * 11 + 3);
			acc(1'b1, 4'hE, lo);
			chk(pout[23:16], lo);
			acc(1'b0, 4'hE, 8'h00);
			chk(rv, {cfg[3] ? ext[23:20] : lo[7:4], cfg[0] ? ext[19:16] : lo[3:0]});
		end
		// Output port holds and reads back the written byte
		acc(1'b1, 4'hF, 8'h80);
		acc(1'b1, 4'hC, 8'h96);
		acc(1'b0, 4'hC, 8'h00);
		chk(rv, 8'h96);
		chk(pout[7:0], 8'h96);
		// Single-bit set on the first port by read, merge and write
		acc(1'b1, 4'hC, rv | 8'h01);
		acc(1'b0, 4'hC, 8'h00);
		chk(rv, 8'h97);
		// Second port output holds and drives its byte
		acc(1'b1, 4'hD, 8'h3C);
		acc(1'b0, 4'hD, 8'h00);
		chk(rv, 8'h3C);
		chk(pout[15:8], 8'h3C);
		// Upper nibble of the third port replaced, lower kept by merging
		acc(1'b0, 4'hE, 8'h00);
		acc(1'b1, 4'hE, {4'h5, rv[3:0]});
		acc(1'b0, 4'hE, 8'h00);
		chk(rv, {4'h5, lo[3:0]});
		acc(1'b0, 4'hF, 8'h00);
		chk(rv, 8'h00);
		// Group mode decode
		for (int m = 0; m < 5; m++) begin
			acc(1'b1, 4'hF, modes[m]);
			chk({o_group_one_mode, o_group_two_mode},
				{modes[m][6] ? 2'b10 : {1'b0, modes[m][5]}, modes[m][2]});
		end
		// Reset in mid-run returns every line to input
		i_reset = 1'b1;
		@(negedge i_clk);
		i_reset = 1'b0;
		chk(poe, 24'h000000);
		chk(o_dac_code, 96'h0);
		final_report();
	end
endmodule
